// ==== udo_rx.sv ====
// Purpose: Device end of an Ultra DMA data-out burst
// Assumes: Host pins sampled by ref_clk through two flip-flops
// Notes: Strobe edges are found on the sampled level
// Notes on behaviour
// - Device starts a burst by asserting its request.
// - Ready driven only after acknowledge delay, held until acknowledge ends.
// - Device asserts ready after stop drops; holds until first strobe.
// - Device pauses only after one word by dropping ready.
// - Device terminates by dropping ready, waiting, then dropping request.
// - Device accepts up to two more words after dropping ready.
// - On host stop device drops request and ready, no reassert.
// - Device ending: ready low, wait, request low; host asserts stop.
// - Closing strobe rise is not a data transfer.
// - CRC latched at acknowledge fall, compared, first error kept.
// - CRC seeded each burst, updated per data edge only.
// - CRC is X16+X12+X5+1, bit 0 shifted first.
// - CRC error sets interface CRC and aborted error bits.
`timescale 1ns/10ps
module udo_rx
  import udo_pkg::*;
#(
  parameter int FIFO_W = udo_pkg::DATA_W,
  parameter int FIFO_D = udo_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic dmack_n,
  input wire logic stop,
  input wire logic hstrobe,
  input wire logic [15:0] dd_in,
  output logic dmarq,
  output logic ddmardy_n_out,
  output logic ddmardy_n_oe,
  input wire logic xfer_start,
  input wire logic xfer_pause,
  input wire logic xfer_end,
  input wire logic cmd_end,
  output logic burst_busy,
  output logic [7:0] error_bits,
  output logic error_valid,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  import udo_pkg::*;
  if (FIFO_W != 16 || FIFO_D < 4) begin : g_bad_fifo
    $error("udo_rx: FIFO must be 16 bits wide, 4 deep or more");
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 16; i++) begin
      if (r[15] ^ d[i])
        r = (r << 1) ^ CRC_POLY;
      else
        r = r << 1;
    end
    return r;
  endfunction : crc_step

  logic ack_s1, ack_s2, stp_s1, stp_s2, stb_s1, stb_s2, stb_d;
  logic [15:0] dd_s1, dd_s2;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      stp_s1 <= 1'b0;
      stp_s2 <= 1'b0;
      stb_s1 <= 1'b1;
      stb_s2 <= 1'b1;
      stb_d <= 1'b1;
      dd_s1 <= '0;
      dd_s2 <= '0;
    end else begin
      ack_s1 <= dmack_n;
      ack_s2 <= ack_s1;
      stp_s1 <= stop;
      stp_s2 <= stp_s1;
      stb_s1 <= hstrobe;
      stb_s2 <= stb_s1;
      stb_d <= stb_s2;
      dd_s1 <= dd_in;
      dd_s2 <= dd_s1;
    end
  end
  // Data synchroniser follows strobe by equal depth, so setup carries over
  logic stb_edge, ack_fall, ack_on;
  assign stb_edge = stb_s2 ^ stb_d;
  assign ack_on = !ack_s2;

  udo_fifo_if #(.W(FIFO_W)) fif ();
  udo_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr(fif.snk),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  udo_state_t st, next_st;
  logic [15:0] crc, next_crc;
  logic [7:0] cnt, next_cnt;
  logic rdy, next_rdy, drive, next_drive, moved, next_moved;
  logic err, next_err, ack_d, next_ack_d;
  logic [7:0] next_error_bits;
  logic next_error_valid;
  logic data_edge;
  assign ack_fall = ack_d && ack_s2;
  // Ready also drops while FIFO has little room: two extra words may land
  // Own fill count, so ready drops with two slots still free
  localparam int FILL_W = $clog2(FIFO_D) + 1;
  logic [FILL_W-1:0] fill, next_fill;
  logic room;
  assign room = fif.ready && (fill < FILL_W'(FIFO_D - 2));
  // data edges before stop; none once stop is seen
  assign data_edge = stb_edge && (st == ST_XFER || st == ST_DRAIN)
                     && !stp_s2;
  assign fif.valid = data_edge;
  assign fif.data = dd_s2;

  always_comb begin
    next_st = st;
    next_crc = crc;
    next_cnt = cnt;
    next_rdy = rdy;
    next_drive = drive;
    next_moved = moved;
    next_err = err;
    next_ack_d = ack_on;
    next_error_bits = error_bits;
    next_error_valid = 1'b0;
    next_fill = fill + FILL_W'(data_edge)
                - FILL_W'(out_valid && out_ready);
    if (data_edge) begin
      next_crc = crc_step(crc, dd_s2);
      next_moved = 1'b1;
    end
    case (st)
      ST_IDLE: begin
        if (xfer_start && ack_s2) begin
          next_st = ST_REQ;
          next_crc = CRC_SEED;
          next_moved = 1'b0;
          next_cnt = '0;
        end
      end
      ST_REQ: begin
        if (ack_on) begin
          if (cnt < 8'(T_ZIORDY_CYC))
            next_cnt = cnt + 8'h01;
          else
            next_drive = 1'b1;
          if (drive && !stp_s2) begin
            next_rdy = 1'b1;
            next_st = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        next_cnt = '0;
        if (stp_s2) begin
          next_rdy = 1'b0;
          next_st = ST_TERM;
        end else if (moved && (xfer_end || xfer_pause || !room)) begin
          next_rdy = 1'b0;
          next_st = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (stp_s2) begin
          next_st = ST_TERM;
        end else if (xfer_end) begin
          if (cnt < 8'(T_RP_CYC))
            next_cnt = cnt + 8'h01;
          else
            next_st = ST_TERM;
        end else if (!xfer_pause && room) begin
          next_rdy = 1'b1;
          next_st = ST_XFER;
        end
      end
      ST_TERM: begin
        next_rdy = 1'b0;
        if (ack_fall) begin
          next_drive = 1'b0;
          next_st = ST_DONE;
          if (dd_s2 != crc && !err) begin
            next_err = 1'b1;
          end
        end
      end
      ST_DONE: begin
        next_st = ST_IDLE;
      end
      default: next_st = ST_IDLE;
    endcase
    if (cmd_end) begin
      next_error_bits = '0;
      next_error_bits[ERR_INTERFACE_CRC_ERROR_BIT] = next_err;
      next_error_bits[ERR_COMMAND_ABORTED_BIT] = next_err;
      next_error_valid = 1'b1;
      next_err = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ST_IDLE;
      crc <= CRC_SEED;
      cnt <= '0;
      rdy <= 1'b0;
      drive <= 1'b0;
      moved <= 1'b0;
      err <= 1'b0;
      ack_d <= 1'b0;
      fill <= '0;
      error_bits <= '0;
      error_valid <= 1'b0;
    end else begin
      st <= next_st;
      crc <= next_crc;
      cnt <= next_cnt;
      rdy <= next_rdy;
      drive <= next_drive;
      moved <= next_moved;
      err <= next_err;
      ack_d <= next_ack_d;
      fill <= next_fill;
      error_bits <= next_error_bits;
      error_valid <= next_error_valid;
    end
  end
  // Request held from start until stop or device end
  assign dmarq = (st == ST_REQ) || (st == ST_XFER) || (st == ST_DRAIN);
  assign ddmardy_n_out = !rdy;
  assign ddmardy_n_oe = drive;
  assign burst_busy = st != ST_IDLE;
endmodule : udo_rx

// ==== udo_pkg.sv ====
// Purpose: Shared constants for the data-out burst receiver
// Assumes: 100 MHz ref_clk
// Notes: Interface timing figures are plain defaults in ns
package udo_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_RP_NS = 160;
  localparam int unsigned T_ZIORDY_NS = 20;
  localparam int unsigned T_RP_CYC =
    (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_ZIORDY_CYC =
    (T_ZIORDY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int unsigned ERR_INTERFACE_CRC_ERROR_BIT = 7;
  localparam int unsigned ERR_COMMAND_ABORTED_BIT = 2;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_XFER = 3'b011,
    ST_DRAIN = 3'b010,
    ST_TERM = 3'b110,
    ST_DONE = 3'b111
  } udo_state_t;
endpackage : udo_pkg

// ==== udo_fifo_if.sv ====
// Purpose: Stream link between receiver and its word FIFO
// Assumes: Single clock
// Notes: Valid/ready handshake
`timescale 1ns/10ps
interface udo_fifo_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : udo_fifo_if

// ==== udo_fifo.sv ====
// Purpose: Word FIFO between strobe capture and the user side
// Assumes: DEPTH is a power of two
// Notes: Full and empty come straight from the pointers
`timescale 1ns/10ps
module udo_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  udo_fifo_if.snk wr,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("udo_fifo: DEPTH must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic do_wr, do_rd;
  assign wr.ready = (wp - rp) != (AW+1)'(DEPTH);
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = out_valid && out_ready;
  always_comb begin
    next_wp = wp + (AW+1)'(do_wr);
    next_rp = rp + (AW+1)'(do_rd);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (do_wr)
      mem[wp[AW-1:0]] <= wr.data;
  end
endmodule : udo_fifo

// ==== udo_monitor.sv ====
// Purpose: Pin checks for the data-out receiver
// Assumes: One clock domain
// Notes: Bound to udo_rx below
`timescale 1ns/10ps
module udo_monitor
  import udo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic dmack_n,
  input wire logic stop,
  input wire logic dmarq,
  input wire logic ddmardy_n_out,
  input wire logic ddmardy_n_oe,
  input wire logic burst_busy,
  input wire logic [7:0] error_bits,
  input wire logic error_valid
);
  int unsigned hi_cnt;
  int unsigned next_hi_cnt;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Counts ready-negated cycles so the request drop can be timed
  always_comb next_hi_cnt = ddmardy_n_out ? hi_cnt + 1 : 0;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) hi_cnt <= 0;
    else hi_cnt <= next_hi_cnt;
  sequence s_stop_seen;
    $rose(stop) && !dmack_n && dmarq;
  endsequence
  sequence s_ack_off;
    $rose(dmack_n) && ddmardy_n_oe;
  endsequence
  chk_ack_wait: assert property (
    $fell(dmack_n) |-> !ddmardy_n_oe [*2])
    else $error("ready driven early");
  chk_ready_held: assert property (
    ddmardy_n_oe && !dmack_n |=> ddmardy_n_oe)
    else $error("ready released early");
  chk_ready_req: assert property (
    $fell(ddmardy_n_out) |-> dmarq)
    else $error("ready without request");
  chk_stop_req: assert property (
    s_stop_seen |-> ##[0:6] !dmarq)
    else $error("request kept after stop");
  chk_stop_rdy: assert property (
    s_stop_seen |-> ##[0:8] ddmardy_n_out)
    else $error("ready kept after stop");
  chk_rp_wait: assert property (
    $fell(dmarq) && !stop |-> hi_cnt >= T_RP_CYC)
    else $error("request dropped too soon");
  chk_ack_rel: assert property (
    s_ack_off |-> ##[1:6] !ddmardy_n_oe)
    else $error("ready not released");
  chk_err_bits: assert property (
    error_valid |-> error_bits[ERR_INTERFACE_CRC_ERROR_BIT] == error_bits[ERR_COMMAND_ABORTED_BIT])
    else $error("error bits differ");
  chk_idle_quiet: assert property (
    !burst_busy |-> !dmarq && !ddmardy_n_oe)
    else $error("idle but driving");
endmodule : udo_monitor
bind udo_rx udo_monitor i_udo_monitor (.ref_clk(ref_clk), .reset_n(reset_n),
  .dmack_n(dmack_n), .stop(stop), .dmarq(dmarq),
  .ddmardy_n_out(ddmardy_n_out), .ddmardy_n_oe(ddmardy_n_oe),
  .burst_busy(burst_busy), .error_bits(error_bits),
  .error_valid(error_valid));

// ==== udo_host.sv ====
// Purpose: Host adapter model for data-out bursts
// Assumes: Strobe half period 62.5 ns
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/10ps
module udo_host (
  output logic dmack_n,
  output logic stop,
  output logic hstrobe,
  output logic [15:0] dd_in,
  input wire logic dmarq,
  input wire logic ddmardy_n_out,
  input wire logic ddmardy_n_oe
);
  initial begin
    dmack_n = 1'b1;
    stop = 1'b1;
    hstrobe = 1'b1;
    dd_in = 16'h0000;
  end
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [15:0] d);
    for (int i = 0; i < 16; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc_step
  task automatic burst(input logic [15:0] w [16], input int n,
      input bit host_end, input bit bad, output int cnt);
    logic [15:0] crc;
    crc = 16'h4ABA;
    cnt = 0;
    // Waits end on a clock edge; step off it before touching a pin
    wait (dmarq);
    #1 dd_in = w[0];
    #20 dmack_n = 1'b0;
    #30 stop = 1'b0;
    wait (ddmardy_n_oe && !ddmardy_n_out);
    #61;
    while (cnt < n && dmarq) begin
      // Pauses on the next edge only; sync lag gives at most one extra word
      if (ddmardy_n_out) begin
        wait (!ddmardy_n_out || !dmarq);
        #1;
      end else begin
        dd_in = w[cnt];
        #20 hstrobe = ~hstrobe;
        crc = crc_step(crc, w[cnt]);
        cnt++;
        #42.5;
      end
    end
    if (host_end) #60 stop = 1'b1;
    wait (!dmarq && ddmardy_n_out);
    #1 stop = 1'b1;
    #20 hstrobe = 1'b1;
    dd_in = crc ^ {15'h0000, bad};
    #60 dmack_n = 1'b1;
    #20 dd_in = ~dd_in;
  endtask : burst
endmodule : udo_host

// ==== testbench.sv ====
// Purpose: Self-checking bench for the data-out receiver
// Assumes: Host model drives the link pins
// Notes: Words and out_ready come from an LFSR seeded with 28
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic dmack_n, stop, hstrobe, dmarq, ddmardy_n_out, ddmardy_n_oe;
  logic xfer_start = 1'b0, xfer_pause = 1'b0, xfer_end = 1'b0;
  logic cmd_end = 1'b0, out_ready = 1'b0, stall = 1'b0;
  logic burst_busy, error_valid, out_valid;
  logic [7:0] error_bits;
  logic [15:0] dd_in, out_data, lf = 16'h001C, rr = 16'h001C;
  logic [15:0] w [16];
  logic [15:0] got [$];
  int miscompares = 0, checked = 0, cnt;
  always #5 ref_clk = ~ref_clk;
  udo_rx i_udo_rx (.ref_clk(ref_clk), .reset_n(reset_n), .dmack_n(dmack_n),
    .stop(stop), .hstrobe(hstrobe), .dd_in(dd_in), .dmarq(dmarq),
    .ddmardy_n_out(ddmardy_n_out), .ddmardy_n_oe(ddmardy_n_oe),
    .xfer_start(xfer_start), .xfer_pause(xfer_pause), .xfer_end(xfer_end),
    .cmd_end(cmd_end), .burst_busy(burst_busy), .error_bits(error_bits),
    .error_valid(error_valid), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  udo_host i_udo_host (.dmack_n(dmack_n), .stop(stop), .hstrobe(hstrobe),
    .dd_in(dd_in), .dmarq(dmarq), .ddmardy_n_out(ddmardy_n_out),
    .ddmardy_n_oe(ddmardy_n_oe));
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, a, e);
    end
  endtask : cmp
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    rr <= lfsr(rr);
    out_ready <= !stall && rr[0];
    if (out_valid && out_ready) got.push_back(out_data);
  end
  // Mode 0 host end, 1 device end, 2 device pause, 3 user side stall
  task automatic run(input int n, input int mode, input bit bad);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      w[i] = lf;
    end
    if (mode == 3) w[0] = 16'hFFFF;
    got.delete();
    @(posedge ref_clk) xfer_start <= 1'b1;
    @(posedge ref_clk) xfer_start <= 1'b0;
    fork
      i_udo_host.burst(w, n, mode != 1, bad, cnt);
      begin
        wait (got.size() >= 1);
        @(posedge ref_clk) xfer_end <= mode == 1;
        xfer_pause <= mode == 2;
        stall <= mode == 3;
        repeat (300) @(posedge ref_clk);
        xfer_end <= 1'b0;
        xfer_pause <= 1'b0;
        stall <= 1'b0;
      end
    join
    repeat (60) @(posedge ref_clk);
    cmp(16'(burst_busy), 16'h0000);
    cmp(16'(got.size()), 16'(cnt));
    for (int i = 0; i < cnt; i++) cmp(got[i], w[i]);
    if (mode == 1) cmp(16'(cnt < n), 16'h0001);
  endtask : run
  task automatic cmd(input logic [7:0] e);
    int k;
    k = 0;
    @(posedge ref_clk) cmd_end <= 1'b1;
    @(posedge ref_clk) cmd_end <= 1'b0;
    #1;
    while (error_valid !== 1'b1 && k < 6) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    cmp(16'(error_valid), 16'h0001);
    cmp({8'h00, error_bits}, {8'h00, e});
  endtask : cmd
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    run(5, 0, 1'b0);
    cmd(8'h00);
    run(16, 2, 1'b1);
    run(16, 1, 1'b0);
    cmd(8'h84);
    run(16, 3, 1'b0);
    run(1, 0, 1'b0);
    cmd(8'h00);
    stop_test;
  end
  initial begin
    #400000;
    miscompares++;
    stop_test;
  end
endmodule : testbench
